// ===== common/bta_defs.svh
// Register offsets, field positions, reset values and timing counts of the bit-test/compare/divide unit
`ifndef BTA_DEFS_SVH
`define BTA_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define BTA_ADDR_W 8
`define BTA_REG_CMD 8'h00
`define BTA_REG_OPA 8'h04
`define BTA_REG_OPB 8'h08
`define BTA_REG_OPHI 8'h0C
`define BTA_REG_LIT 8'h10
`define BTA_REG_STATUS 8'h14
`define BTA_REG_RESULT 8'h18
`define BTA_REG_REMAIN 8'h1C

// ----------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------
`define BTA_ST_FLAGS_MSB 4
`define BTA_ST_BUSY 8
`define BTA_ST_SKIP 9
`define BTA_ST_IRQB 10

// ----------------------------------------------------------------
// Field widths and reset values
// ----------------------------------------------------------------
`define BTA_CMD_W 10
`define BTA_LIT_W 14
`define BTA_RST_WORD 16'h0000
`define BTA_RST_FLAGS 5'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BTA_DIV_CYCLES 18
`define BTA_DIV_LAST_STEP 5'h10

`endif

// ===== common/bta_pkg.sv
// Types shared by the bit-test/compare/divide unit
package bta_pkg;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    BTA_BIT_TEST_SKIP_SET,
    BTA_BIT_TEST_ONLY,
    BTA_BIT_TEST_THEN_SET,
    BTA_COMPARE_OP,
    BTA_COMPARE_ZERO_OP,
    BTA_COMPARE_BORROW_OP,
    BTA_COMPARE_SKIP_EQUAL,
    BTA_COMPARE_SKIP_GREATER,
    BTA_COMPARE_SKIP_LESS,
    BTA_COMPARE_SKIP_UNEQUAL,
    BTA_DECIMAL_ADJUST_OP,
    BTA_TIMED_IRQ_BLOCK,
    BTA_DIVIDE_OP,
    BTA_FIRST_ONE_FROM_MSB,
    BTA_FIRST_ONE_FROM_LSB
  } bta_op_t;

  // Command word, low bits first: op, to_carry, bit_from_reg, lit_src, long_div, signed_div
  typedef struct packed {
    logic signed_div;
    logic long_div;
    logic lit_src;
    logic bit_from_reg;
    logic to_carry;
    bta_op_t op;
  } bta_cmd_t;

  typedef struct packed {
    logic digit_carry_flag;
    logic n;
    logic overflow_flag;
    logic z;
    logic c;
  } bta_flags_t;

  typedef enum logic {BTA_IDLE, BTA_DIV} bta_state_t;

  typedef struct packed {
    bta_state_t state;
    logic [4:0] cnt;
    logic [16:0] p;
    logic [15:0] q;
    logic [15:0] d;
    logic neg_q;
    logic neg_r;
    logic ovf;
    bta_cmd_t cmd;
    logic [15:0] opa;
    logic [15:0] opb;
    logic [15:0] ophi;
    logic [13:0] lit;
    bta_flags_t flags;
    logic [15:0] result;
    logic [15:0] remain;
    logic skip;
    logic skip_req;
    logic result_wr;
    logic [13:0] blk_cnt;
    logic irq_block;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bta_st_t;

endpackage

// ===== src/bta_alu.sv
// Bit-test, compare, decimal-adjust, timed interrupt block, divide and find-first-one datapath
`timescale 1ns/1ns
`include "bta_defs.svh"

module bta_alu (
  input wire logic pclk, // Core clock, 125 MHz
  input wire logic presetn, // Asynchronous reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [`BTA_ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic instr_tick, // One pulse per retired instruction
  output logic skip_req, // Pulse: skip the next instruction
  output logic result_wr, // Pulse: result_data goes to the destination
  output logic [15:0] result_data, // Value for the destination register
  output bta_pkg::bta_flags_t flags, // Status flags
  output logic irq_block, // Interrupts held off
  output logic busy // Divide in progress
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] bta_ff1_msb(input logic [15:0] v);
    logic [4:0] pos;
    pos = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        pos = 5'(16 - i);
      end
    end
    return pos;
  endfunction

  function automatic logic [4:0] bta_ff1_lsb(input logic [15:0] v);
    logic [4:0] pos;
    pos = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        pos = 5'(i + 1);
      end
    end
    return pos;
  endfunction

  // Flags of base - source - !cin as a 16-bit subtraction
  function automatic bta_pkg::bta_flags_t bta_sub_flags(input logic [15:0] a, input logic [15:0] b,
                                                        input logic cin, input logic zin);
    bta_pkg::bta_flags_t f;
    logic [16:0] s;
    logic [4:0] lo;
    s = {1'b0, a} + {1'b0, ~b} + {16'h0000, cin};
    lo = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    f.c = s[16];
    f.digit_carry_flag = lo[4];
    f.n = s[15];
    f.overflow_flag = (a[15] != b[15]) && (s[15] != a[15]);
    f.z = zin && (s[15:0] == 16'h0000);
    return f;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bta_pkg::bta_st_t s_r;
  bta_pkg::bta_st_t s_nxt;

  bta_pkg::bta_cmd_t c_in;
  logic access;
  logic mapped;
  logic issue;
  logic [3:0] bitn;
  logic bitv;
  logic [15:0] src;
  logic [15:0] mask;
  logic [8:0] bcd_adj;
  logic [31:0] dvd;
  logic [31:0] dvd_mag;
  logic [15:0] dvs_mag;
  logic [16:0] shifted;
  logic [15:0] qval;
  logic ovf_end;

  always_comb begin
    s_nxt = s_r;
    c_in = bta_pkg::bta_cmd_t'(pwdata[`BTA_CMD_W-1:0]);
    access = psel && penable && !s_r.pready;
    mapped = 1'b0;
    issue = 1'b0;
    bitn = c_in.bit_from_reg ? s_r.opb[3:0] : s_r.lit[3:0];
    bitv = s_r.opa[bitn];
    mask = 16'h0001 << bitn;
    src = c_in.lit_src ? {11'h000, s_r.lit[4:0]} : s_r.opb;
    bcd_adj = {1'b0, s_r.opa[7:0]};
    dvd = 32'h0000_0000;
    dvd_mag = 32'h0000_0000;
    dvs_mag = 16'h0000;
    shifted = {s_r.p[15:0], s_r.q[15]};
    qval = 16'h0000;
    ovf_end = 1'b0;
    s_nxt.skip_req = 1'b0;
    s_nxt.result_wr = 1'b0;

    // ----------------------------------------------------------------
    // Timed interrupt block countdown
    // ----------------------------------------------------------------
    if (instr_tick && (s_r.blk_cnt != 14'h0000)) begin
      s_nxt.blk_cnt = s_r.blk_cnt - 14'h0001;
    end

    // ----------------------------------------------------------------
    // APB slave: answer in the second access cycle
    // ----------------------------------------------------------------
    s_nxt.pready = access;
    s_nxt.pslverr = 1'b0;
    if (access) begin
      unique case (paddr)
        `BTA_REG_CMD, `BTA_REG_OPA, `BTA_REG_OPB, `BTA_REG_OPHI, `BTA_REG_LIT,
        `BTA_REG_STATUS, `BTA_REG_RESULT, `BTA_REG_REMAIN: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
      s_nxt.pslverr = !mapped;
      s_nxt.prdata = 32'h0000_0000;
      if (pwrite) begin
        unique case (paddr)
          `BTA_REG_CMD: issue = (s_r.state == bta_pkg::BTA_IDLE);
          `BTA_REG_OPA: s_nxt.opa = pwdata[15:0];
          `BTA_REG_OPB: s_nxt.opb = pwdata[15:0];
          `BTA_REG_OPHI: s_nxt.ophi = pwdata[15:0];
          `BTA_REG_LIT: s_nxt.lit = pwdata[`BTA_LIT_W-1:0];
          `BTA_REG_STATUS: s_nxt.flags = bta_pkg::bta_flags_t'(pwdata[`BTA_ST_FLAGS_MSB:0]);
          default: ;
        endcase
      end else begin
        unique case (paddr)
          `BTA_REG_CMD: s_nxt.prdata = {22'h000000, s_r.cmd};
          `BTA_REG_OPA: s_nxt.prdata = {16'h0000, s_r.opa};
          `BTA_REG_OPB: s_nxt.prdata = {16'h0000, s_r.opb};
          `BTA_REG_OPHI: s_nxt.prdata = {16'h0000, s_r.ophi};
          `BTA_REG_LIT: s_nxt.prdata = {18'h00000, s_r.lit};
          `BTA_REG_STATUS: begin
            s_nxt.prdata[`BTA_ST_FLAGS_MSB:0] = s_r.flags;
            s_nxt.prdata[`BTA_ST_BUSY] = (s_r.state == bta_pkg::BTA_DIV);
            s_nxt.prdata[`BTA_ST_SKIP] = s_r.skip;
            s_nxt.prdata[`BTA_ST_IRQB] = s_r.irq_block;
          end
          `BTA_REG_RESULT: s_nxt.prdata = {16'h0000, s_r.result};
          `BTA_REG_REMAIN: s_nxt.prdata = {16'h0000, s_r.remain};
          default: ;
        endcase
      end
    end

    // ----------------------------------------------------------------
    // Command execution; single-cycle ops finish at the issuing edge
    // ----------------------------------------------------------------
    if (issue) begin
      s_nxt.cmd = c_in;
      s_nxt.skip = 1'b0;
      unique case (c_in.op)
        bta_pkg::BTA_BIT_TEST_SKIP_SET: begin
          s_nxt.skip = bitv;
        end
        bta_pkg::BTA_BIT_TEST_ONLY, bta_pkg::BTA_BIT_TEST_THEN_SET: begin
          if (c_in.to_carry) begin
            s_nxt.flags.c = bitv;
          end else begin
            s_nxt.flags.z = !bitv;
          end
          if (c_in.op == bta_pkg::BTA_BIT_TEST_THEN_SET) begin
            s_nxt.result = s_r.opa | mask;
            s_nxt.result_wr = 1'b1;
          end
        end
        bta_pkg::BTA_COMPARE_OP: s_nxt.flags = bta_sub_flags(s_r.opa, src, 1'b1, 1'b1);
        bta_pkg::BTA_COMPARE_ZERO_OP: s_nxt.flags = bta_sub_flags(s_r.opa, 16'h0000, 1'b1, 1'b1);
        bta_pkg::BTA_COMPARE_BORROW_OP: begin
          // Zero only stays set across words, so a multi-word compare ends with a true Z
          s_nxt.flags = bta_sub_flags(s_r.opa, src, s_r.flags.c, s_r.flags.z);
        end
        bta_pkg::BTA_COMPARE_SKIP_EQUAL: s_nxt.skip = (s_r.opa == s_r.opb);
        bta_pkg::BTA_COMPARE_SKIP_GREATER: s_nxt.skip = ($signed(s_r.opa) > $signed(s_r.opb));
        bta_pkg::BTA_COMPARE_SKIP_LESS: s_nxt.skip = ($signed(s_r.opa) < $signed(s_r.opb));
        bta_pkg::BTA_COMPARE_SKIP_UNEQUAL: s_nxt.skip = (s_r.opa != s_r.opb);
        bta_pkg::BTA_DECIMAL_ADJUST_OP: begin
          if ((bcd_adj[3:0] > 4'h9) || s_r.flags.digit_carry_flag) begin
            bcd_adj = bcd_adj + 9'h006;
          end
          if ((bcd_adj[7:4] > 4'h9) || bcd_adj[8] || s_r.flags.c) begin
            bcd_adj = bcd_adj + 9'h060;
          end
          s_nxt.flags.c = s_r.flags.c || bcd_adj[8];
          s_nxt.result = {s_r.opa[15:8], bcd_adj[7:0]};
          s_nxt.result_wr = 1'b1;
        end
        bta_pkg::BTA_TIMED_IRQ_BLOCK: s_nxt.blk_cnt = s_r.lit;
        bta_pkg::BTA_DIVIDE_OP: begin
          if (c_in.long_div) begin
            dvd = {s_r.ophi, s_r.opa};
          end else if (c_in.signed_div) begin
            dvd = {{16{s_r.opa[15]}}, s_r.opa};
          end else begin
            dvd = {16'h0000, s_r.opa};
          end
          dvd_mag = (c_in.signed_div && dvd[31]) ? -dvd : dvd;
          dvs_mag = (c_in.signed_div && s_r.opb[15]) ? -s_r.opb : s_r.opb;
          s_nxt.p = {1'b0, dvd_mag[31:16]};
          s_nxt.q = dvd_mag[15:0];
          s_nxt.d = dvs_mag;
          s_nxt.neg_q = c_in.signed_div && (dvd[31] ^ s_r.opb[15]);
          s_nxt.neg_r = c_in.signed_div && dvd[31];
          // Quotient would need more than 16 bits, or divisor is zero
          s_nxt.ovf = (dvs_mag == 16'h0000) || (dvd_mag[31:16] >= dvs_mag);
          s_nxt.cnt = 5'h00;
          s_nxt.state = bta_pkg::BTA_DIV;
        end
        bta_pkg::BTA_FIRST_ONE_FROM_MSB: begin
          s_nxt.result = {11'h000, bta_ff1_msb(s_r.opa)};
          s_nxt.flags.c = (s_r.opa == 16'h0000);
          s_nxt.result_wr = 1'b1;
        end
        bta_pkg::BTA_FIRST_ONE_FROM_LSB: begin
          s_nxt.result = {11'h000, bta_ff1_lsb(s_r.opa)};
          s_nxt.flags.c = (s_r.opa == 16'h0000);
          s_nxt.result_wr = 1'b1;
        end
        default: ;
      endcase
      s_nxt.skip_req = s_nxt.skip;
    end

    // ----------------------------------------------------------------
    // Restoring divide: 16 steps then one fix-up step
    // ----------------------------------------------------------------
    if (s_r.state == bta_pkg::BTA_DIV) begin
      s_nxt.cnt = s_r.cnt + 5'h01;
      if (s_r.cnt != `BTA_DIV_LAST_STEP) begin
        if (shifted >= {1'b0, s_r.d}) begin
          s_nxt.p = shifted - {1'b0, s_r.d};
          s_nxt.q = {s_r.q[14:0], 1'b1};
        end else begin
          s_nxt.p = shifted;
          s_nxt.q = {s_r.q[14:0], 1'b0};
        end
      end else begin
        // Signed range is asymmetric: -32768 fits, +32768 does not
        ovf_end = s_r.ovf || (s_r.cmd.signed_div && (s_r.neg_q ? (s_r.q > 16'h8000) : s_r.q[15]));
        qval = s_r.neg_q ? -s_r.q : s_r.q;
        s_nxt.result = qval;
        s_nxt.remain = s_r.neg_r ? -s_r.p[15:0] : s_r.p[15:0];
        s_nxt.flags.n = qval[15];
        s_nxt.flags.z = (qval == 16'h0000);
        s_nxt.flags.c = (s_r.p[15:0] != 16'h0000);
        s_nxt.flags.overflow_flag = ovf_end;
        s_nxt.result_wr = 1'b1;
        s_nxt.state = bta_pkg::BTA_IDLE;
      end
    end

    s_nxt.irq_block = (s_nxt.blk_cnt != 14'h0000);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign skip_req = s_r.skip_req;
  assign result_wr = s_r.result_wr;
  assign result_data = s_r.result;
  assign flags = s_r.flags;
  assign irq_block = s_r.irq_block;
  assign busy = (s_r.state == bta_pkg::BTA_DIV);

endmodule

// ===== testbench/bta_alu_assertions.sv
// Port-level concurrent checks for the bit-test/compare/divide unit
`timescale 1ns/1ns
module bta_alu_assertions (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic instr_tick, // Retire pulse
  input wire logic skip_req, // Skip pulse
  input wire logic result_wr, // Write-back pulse
  input wire bta_pkg::bta_flags_t flags, // Flags
  input wire logic irq_block, // Interrupts held off
  input wire logic busy // Divide running
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence div_run;
    busy [*8] ##1 busy [*8] ##1 busy;
  endsequence
  a_skip_flags_kept: assert property (skip_req |-> $stable(flags))
    else $error("flags changed with a skip");
  a_skip_one_cycle: assert property (skip_req |=> !skip_req)
    else $error("skip request longer than one cycle");
  a_div_length: assert property ($rose(busy) |-> div_run ##1 !busy)
    else $error("divide busy time wrong");
  a_div_result_wr: assert property ($fell(busy) |-> result_wr)
    else $error("no write-back at divide end");
  a_busy_no_skip: assert property (busy |-> !skip_req)
    else $error("command issued while busy");
  a_div_dc_kept: assert property ($fell(busy) |-> $stable(flags.digit_carry_flag))
    else $error("divide touched digit carry");
  a_block_release: assert property ($fell(irq_block) |-> $past(instr_tick) || $past(psel && pwrite))
    else $error("interrupt block ended without a tick");
  a_wr_one_cycle: assert property (result_wr |=> !result_wr)
    else $error("write-back longer than one cycle");
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("bus answer late");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule

bind bta_alu bta_alu_assertions chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .instr_tick(instr_tick), .skip_req(skip_req),
  .result_wr(result_wr), .flags(flags), .irq_block(irq_block), .busy(busy));

// ===== testbench/bta_alu_tb.sv
// Self-checking bench for the bit-test/compare/divide unit
`timescale 1ns/1ns
`include "bta_defs.svh"
module bta_alu_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tick_en = 0, pready, pslverr, err;
  logic instr_tick, skip_req, result_wr, irq_block, busy;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] result_data, dest;
  logic [4:0] ef;
  bta_pkg::bta_flags_t flags;
  int skips, held, n, s0, mismatches = 0, checks = 0;
  logic [15:0] ca[6] = '{16'h0005, 16'h8000, 16'h0000, 16'h0003, 16'h0003, 16'h0010};
  logic [15:0] cb[6] = '{16'h0005, 16'h0007, 16'h1234, 16'h0003, 16'h0003, 16'h0002};
  logic [9:0] cc[6] = '{10'h003, 10'h083, 10'h004, 10'h005, 10'h005, 10'h085};
  logic [4:0] cf[6] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h03, 5'h01};
  logic [15:0] sa[3] = '{16'hFFFF, 16'h0001, 16'h8000}, sb[3] = '{16'h0001, 16'hFFFF, 16'h8000};
  logic [3:0] sm[3] = '{4'b1100, 4'b1010, 4'b0001};
  logic [9:0] dvc[5] = '{10'h00C, 10'h30C, 10'h20C, 10'h10C, 10'h00C};
  logic [15:0] da[5] = '{16'h0064, 16'hFF9C, 16'hFF9C, 16'h0000, 16'h0005};
  logic [15:0] dh[5] = '{16'hFFFF, 16'hFFFF, 16'h0000, 16'h0001, 16'h0000};
  logic [15:0] db[5] = '{16'h0007, 16'h0007, 16'h0007, 16'h0007, 16'h0000};
  logic [15:0] dq[4] = '{16'h000E, 16'hFFF2, 16'hFFF2, 16'h2492}, dr[4] = '{16'h0002, 16'hFFFE, 16'hFFFE, 16'h0002};
  logic [4:0] df[5] = '{5'h11, 5'h19, 5'h19, 5'h11, 5'h14}, dm[5] = '{5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h14};
  always #4 pclk = ~pclk;
  bta_alu dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_tick(instr_tick),
    .skip_req(skip_req), .result_wr(result_wr), .result_data(result_data), .flags(flags),
    .irq_block(irq_block), .busy(busy));
  bta_core_model core_u (.pclk(pclk), .presetn(presetn), .tick_en(tick_en), .irq_block(irq_block),
    .skip_req(skip_req), .result_wr(result_wr), .result_data(result_data), .instr_tick(instr_tick),
    .skips(skips), .held(held), .dest(dest));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin mismatches++; test_done; end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wait_clear(input bit blk);
    n = 0;
    while ((blk ? irq_block : busy) !== 1'b0 && n < 64) begin @(posedge pclk); n++; end
    if (n >= 64) begin mismatches++; test_done; end
  endtask
  task automatic setop(input logic [15:0] a, input logic [15:0] b, input logic [13:0] l);
    apb(1'b1, `BTA_REG_OPA, {16'h0, a}); apb(1'b1, `BTA_REG_OPB, {16'h0, b}); apb(1'b1, `BTA_REG_LIT, {18'h0, l});
  endtask
  task automatic cmd(input logic [9:0] c);
    apb(1'b1, `BTA_REG_CMD, {22'h0, c});
  endtask
  task automatic flg(input logic [4:0] f);
    apb(1'b1, `BTA_REG_STATUS, {27'h0, f});
  endtask
  function automatic logic [4:0] cmpf(input logic [15:0] a, b, input logic bin, compare_borrow_op, oldz);
    logic [16:0] d;
    logic [4:0] l;
    d = {1'b0, a} - {1'b0, b} - 17'(bin);
    l = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(bin);
    return {~l[4], d[15], (a[15] ^ b[15]) & (d[15] ^ a[15]), (d[15:0] == 16'h0) & (oldz | ~compare_borrow_op), ~d[16]};
  endfunction
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `BTA_REG_STATUS, 32'h0); chk("status reset", rd, 32'h0);
    chk("mapped no err", err, 0);
    apb(1'b0, 8'h20, 32'h0); chk("unmapped err", err, 1); chk("unmapped data", rd, 32'h0);
    setop(16'h0010, 16'h0004, 14'h0004); flg(5'h15);
    cmd(10'h000); chk("skip flags", flags, 5'h15);
    apb(1'b1, `BTA_REG_LIT, 32'h3); chk("skip taken", skips, 1);
    cmd(10'h000); flg(5'h00); chk("no skip", skips, 1);
    cmd(10'h001); chk("test to z", flags, 5'h02);
    cmd(10'h061); chk("test reg to c", flags, 5'h03);
    apb(1'b1, `BTA_REG_LIT, 32'h1); cmd(10'h022); chk("test set c", flags, 5'h02);
    apb(1'b0, `BTA_REG_RESULT, 32'h0); chk("test set value", dest, 16'h0012);
    for (int i = 0; i < 6; i++) begin
      setop(ca[i], cb[i], 14'h3FE0 | 14'(cb[i])); flg(cf[i]); cmd(cc[i]);
      ef = cmpf(ca[i], cc[i][4:0] == 5'h04 ? 16'h0 : cb[i], (cc[i][4:0] == 5'h05) & ~cf[i][0],
        cc[i][4:0] == 5'h05, cf[i][1]);
      chk("compare flags", flags, ef);
    end
    chk("compare no write", dest, 16'h0012);
    flg(5'h1F);
    for (int j = 0; j < 3; j++) begin
      setop(sa[j], sb[j], 14'h0);
      for (int k = 0; k < 4; k++) begin
        s0 = skips; cmd(10'(6 + k)); apb(1'b0, `BTA_REG_STATUS, 32'h0);
        chk("compare skip", skips - s0, sm[j][k]);
      end
    end
    chk("skip flags kept", flags, 5'h1F);
    setop(16'h129A, 16'h0, 14'h0); flg(5'h00); cmd(10'h00A); chk("adjust flags", flags, 5'h01);
    apb(1'b0, `BTA_REG_RESULT, 32'h0); chk("adjust value", dest, 16'h1200);
    for (int j = 0; j < 2; j++) begin
      setop(j ? 16'h0000 : 16'h0410, 16'h0, 14'h0); flg(5'h1E); cmd(10'h00D);
      chk("msb flags", flags, {4'hF, 1'(j)}); apb(1'b0, `BTA_REG_RESULT, 32'h0);
      chk("msb pos", dest, j ? 16'h0 : 16'h6); cmd(10'h00E); chk("lsb flags", flags, {4'hF, 1'(j)});
      apb(1'b0, `BTA_REG_RESULT, 32'h0); chk("lsb pos", dest, j ? 16'h0 : 16'h5);
    end
    for (int i = 0; i < 5; i++) begin
      flg(5'h10); setop(da[i], db[i], 14'h0005); apb(1'b1, `BTA_REG_OPHI, {16'h0, dh[i]});
      cmd(dvc[i]);
      if (i == 0) cmd(10'h00B);
      wait_clear(1'b0);
      chk("refused while busy", irq_block, 0);
      chk("divide flags", 5'(flags) & dm[i], df[i]);
      if (i < 4) begin
        apb(1'b0, `BTA_REG_RESULT, 32'h0); chk("quotient", rd, {16'h0, dq[i]});
        apb(1'b0, `BTA_REG_REMAIN, 32'h0); chk("remainder", rd, {16'h0, dr[i]});
      end
    end
    apb(1'b1, `BTA_REG_LIT, 32'h3); flg(5'h0A); cmd(10'h00B);
    chk("block on", irq_block, 1); chk("block flags", flags, 5'h0A);
    @(posedge pclk);
    tick_en <= 1'b1;
    wait_clear(1'b1);
    tick_en <= 1'b0;
    chk("blocked count", held, 3);
    test_done;
  end
endmodule

// ===== testbench/bta_core_model.sv
// Core-side model: retires instructions, records skips and write-backs
`timescale 1ns/1ns
module bta_core_model (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic tick_en, // Let instructions retire
  input wire logic irq_block, // Interrupts held off
  input wire logic skip_req, // Skip pulse
  input wire logic result_wr, // Write-back pulse
  input wire logic [15:0] result_data, // Write-back value
  output logic instr_tick, // Retire pulse
  output int skips, // Skips taken
  output int held, // Retired while blocked
  output logic [15:0] dest // Destination copy
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_tick <= 1'b0;
      skips <= 0;
      held <= 0;
      dest <= 16'h0000;
    end else begin
      instr_tick <= tick_en;
      if (skip_req) skips <= skips + 1;
      if (instr_tick && irq_block) held <= held + 1;
      if (result_wr) dest <= result_data;
    end
  end
endmodule
